// ---- inc/dio_pkg.sv ----
// Purpose: Constants and carriers for the isolated digital I/O core.
// Assumes: 20 MHz system clock; filter base of 8 MHz made by a phase step.
// Notes:   Host register access is by plain ports, no bus.
package dio_pkg;

  localparam int unsigned CHANNELS    = 32;
  localparam int unsigned SET_W       = 5;
  localparam logic [4:0]  SET_MAX     = 5'h14;
  localparam logic [4:0]  SET_RESET   = 5'h00;
  localparam logic [31:0] OUT_RESET   = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] EDGE_RESET  = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET  = 32'h0000_0000;
  // Base rate 8 MHz from 20 MHz: accumulate 2 per clock, wrap at 5
  localparam int unsigned SYS_HZ      = 20_000_000;
  localparam int unsigned BASE_HZ     = 8_000_000;
  localparam int unsigned GCD_HZ      = 4_000_000;
  localparam logic [2:0]  PHASE_STEP  = 3'(BASE_HZ / GCD_HZ);
  localparam logic [2:0]  PHASE_MOD   = 3'(SYS_HZ / GCD_HZ);
  localparam int unsigned CNT_W       = 21;

  typedef logic [CHANNELS-1:0] word_t;

  // Host-side interrupt configuration
  typedef struct packed {
    word_t mask_enable;
    word_t edge_falling;
  } irq_cfg_s;

endpackage : dio_pkg

// ---- rtl/dio_core.sv ----
// Purpose: 32-in/32-out digital I/O core with debounce and edge interrupts.
// Assumes: Inputs are asynchronous pins; host strobes are on clock_i.
// Notes:   Filter ticks at an average 8 MHz, jitter is one system clock.
`timescale 1ns/1ps
module dio_core (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     srst_i,
  // Field pins, active when the external device is on
  input  wire logic [31:0]              field_in_i,
  output logic      [31:0]              field_out_o,
  // Host output latch write
  input  wire logic                     out_wr_i,
  input  wire logic [31:0]              out_data_i,
  // Host filter setting write
  input  wire logic                     filt_wr_i,
  input  wire logic [4:0]               filt_data_i,
  // Host interrupt configuration write
  input  wire logic                     cfg_wr_i,
  input  wire dio_pkg::irq_cfg_s        cfg_data_i,
  // Host status read strobe
  input  wire logic                     stat_rd_i,
  // Host readback
  output logic      [31:0]              in_data_o,
  output logic      [31:0]              out_readback_o,
  output logic      [4:0]               filt_setting_o,
  output dio_pkg::irq_cfg_s             cfg_readback_o,
  output logic      [31:0]              status_o,
  output logic                          irq_o
);
  import dio_pkg::*;

  word_t              sync_a;
  word_t              sync_b;
  word_t              filt_lvl;
  word_t              filt_prev;
  word_t              edge_hit;
  word_t              next_status;
  logic [2:0]         phase;
  logic               base_tick;
  logic [CNT_W-1:0]   stable_cnt [CHANNELS];
  logic [CNT_W-1:0]   limit;

  // Output latches; field drive mirrors the latch
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      out_readback_o <= OUT_RESET;
      field_out_o    <= OUT_RESET;
    end
    else if (out_wr_i)
    begin
      out_readback_o <= out_data_i;
      field_out_o    <= out_data_i;
    end
  end

  // Filter setting; out-of-range values are kept but saturated below
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      filt_setting_o <= SET_RESET;
    else if (filt_wr_i)
      filt_setting_o <= filt_data_i;
  end

  // Interrupt configuration
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      cfg_readback_o <= '{mask_enable: MASK_RESET,
                          edge_falling: EDGE_RESET};
    else if (cfg_wr_i)
      cfg_readback_o <= cfg_data_i;
  end

  // Two-stage synchronizer on the field inputs
  // The first stage may go metastable, so only the second is read
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= field_in_i;
      sync_b <= sync_a;
    end
  end

  // Fractional divider: two base ticks every five system clocks
  // An exact 8 MHz would need a second clock; one clock of jitter
  // per tick is traded for keeping the whole core in one domain
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      phase     <= '0;
      base_tick <= 1'b0;
    end
    else if (phase + PHASE_STEP >= PHASE_MOD)
    begin
      phase     <= phase + PHASE_STEP - PHASE_MOD;
      base_tick <= 1'b1;
    end
    else
    begin
      phase     <= phase + PHASE_STEP;
      base_tick <= 1'b0;
    end
  end

  // Stability limit of 2**n base periods, n clamped to the legal range
  // An out-of-range write is a software fault; clamping keeps it harmless
  always_comb
  begin
    if (filt_setting_o > SET_MAX)
      limit = CNT_W'(1) << SET_MAX;
    else
      limit = CNT_W'(1) << filt_setting_o;
  end

  // Per-channel debounce, all sharing one limit
  // A count restarts whenever the level agrees again, so a short
  // excursion never accumulates toward a change
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_filt
      always_ff @(posedge clock_i)
      begin
        if (srst_i)
        begin
          stable_cnt[ch] <= '0;
          filt_lvl[ch]   <= 1'b0;
        end
        else if (filt_setting_o == SET_RESET)
        begin
          stable_cnt[ch] <= '0;
          filt_lvl[ch]   <= sync_b[ch];
        end
        else if (sync_b[ch] == filt_lvl[ch])
          stable_cnt[ch] <= '0;
        else if (base_tick)
        begin
          if (stable_cnt[ch] + CNT_W'(1) >= limit)
          begin
            filt_lvl[ch]   <= sync_b[ch];
            stable_cnt[ch] <= '0;
          end
          else
            stable_cnt[ch] <= stable_cnt[ch] + CNT_W'(1);
        end
      end
    end
  endgenerate

  // Host view of the filtered inputs
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      in_data_o <= '0;
    else
      in_data_o <= filt_lvl;
  end

  // Edge detection on the filtered levels
  // Reset value matches the filter's reset, so no false edge follows
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      filt_prev <= '0;
    else
      filt_prev <= filt_lvl;
  end

  // Rising when edge bit is 0, falling when 1; masked bits never hit
  assign edge_hit = cfg_readback_o.mask_enable &
                    (( filt_lvl & ~filt_prev & ~cfg_readback_o.edge_falling)
                   | (~filt_lvl &  filt_prev &  cfg_readback_o.edge_falling));

  // Read clears, but a same-cycle edge survives the clear
  // Set wins so that an edge arriving with the read is never lost
  always_comb
  begin
    next_status = (stat_rd_i ? '0 : status_o) | edge_hit;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      status_o <= STAT_RESET;
      irq_o    <= 1'b0;
    end
    else
    begin
      status_o <= next_status;
      irq_o    <= |next_status;
    end
  end

  // Assertions, grouped by the concern that they guard.
  // They check what this core drives, reading the stimulus only as trigger or reference.

  // Output latch: a write reaches the pins on the next edge
  // Downstream loads see the new value one clock after the strobe
  out_latch_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    out_wr_i |=> field_out_o == $past(out_data_i))
    else $error("output latch did not take write");

  // Reset leaves every transistor off and every status bit clear
  // A reset in mid-run must not leave a stray load switched on
  out_reset_a: assert property (
    @(posedge clock_i)
    srst_i |=> field_out_o == '0 && status_o == '0)
    else $error("reset did not clear latches");

  // Readback is a copy of the drive, so reading cannot disturb it
  // Both registers load from one strobe and must never part ways
  readback_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    out_readback_o == field_out_o)
    else $error("readback differs from drive");

  // Filter setting: the written value is held for readback
  // One register serves every channel, so one check covers them all
  filt_write_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    filt_wr_i |=> filt_setting_o == $past(filt_data_i))
    else $error("filter setting did not take write");

  // Reset leaves the filter off and interrupts fully disabled
  // Software may rely on a quiet core before it configures anything
  cfg_reset_a: assert property (
    @(posedge clock_i)
    srst_i |=> filt_setting_o == '0 && cfg_readback_o == '0)
    else $error("reset did not clear configuration");

  // Interrupt configuration is stored whole from one strobe
  // A half-written mask could let a stray edge through
  cfg_write_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    cfg_wr_i |=> cfg_readback_o == $past(cfg_data_i))
    else $error("interrupt configuration did not take write");

  // Synchronizer: the filter sees each pin exactly two edges late
  // A shorter path would expose the filter to metastable values
  sync_delay_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    sync_b == $past(field_in_i, 2))
    else $error("synchronizer delay wrong");

  // Bypass: with setting 0 the data port tracks the synchronizer
  // The clause on a changed setting excuses the switching cycle
  bypass_follow_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    filt_setting_o == '0 && $stable(filt_setting_o)
    |=> in_data_o == $past(sync_b, 2) || $changed(filt_setting_o))
    else $error("bypass did not follow input");

  // Filter: with the level already agreed, nothing may move it
  // A glitch that has returned must leave no trace in the level
  glitch_drop_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    filt_setting_o != '0 && sync_b == filt_lvl
    |=> $stable(filt_lvl) || $changed(filt_setting_o))
    else $error("filtered level moved without cause");

  // Filter: a held-off level may move only on a base tick
  // Time is measured in base periods, never in system clocks
  tick_only_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    filt_setting_o != '0 && !base_tick |=> $stable(filt_lvl))
    else $error("filtered level moved between ticks");

  // Interrupt level always mirrors the status word
  // The request drops only once every flagged source is read
  irq_level_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    irq_o == (status_o != '0))
    else $error("interrupt not tied to status");

  // Edge select on bit 0 as representative: rising when cleared
  rise_sets_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    cfg_readback_o.mask_enable[0] && !cfg_readback_o.edge_falling[0]
    && filt_lvl[0] && !filt_prev[0] |=> status_o[0])
    else $error("rising edge missed");

  // Edge select on bit 0 as representative: falling when set
  fall_sets_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    cfg_readback_o.mask_enable[0] && cfg_readback_o.edge_falling[0]
    && !filt_lvl[0] && filt_prev[0] |=> status_o[0])
    else $error("falling edge missed");

  // Masked bit 0 as representative: its status cannot rise, whatever the pin does
  // Masking must hold even while the level keeps toggling
  masked_bit_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !cfg_readback_o.mask_enable[0] && !status_o[0] |=> !status_o[0])
    else $error("masked bit set its status");

  // With every bit masked, a read leaves the status empty
  masked_quiet_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    stat_rd_i && cfg_readback_o.mask_enable == '0 |=> status_o == '0)
    else $error("masked input set status");

  // A read with no edge pending clears status and request
  // When an edge coincides, set wins and this check stands aside
  read_clear_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    stat_rd_i && edge_hit == '0 |=> status_o == '0 && !irq_o)
    else $error("status read did not clear");

  // Main scenarios that the bench is expected to reach
  irq_raised_c: cover property (@(posedge clock_i) disable iff (srst_i)
    $rose(irq_o));
  irq_cleared_c: cover property (@(posedge clock_i) disable iff (srst_i)
    irq_o ##1 stat_rd_i ##1 !irq_o);
  filt_change_c: cover property (@(posedge clock_i) disable iff (srst_i)
    filt_setting_o != '0 && $changed(filt_lvl));
  fall_edge_c: cover property (@(posedge clock_i) disable iff (srst_i)
    cfg_readback_o.edge_falling[0] && $rose(status_o[0]));
  masked_move_c: cover property (@(posedge clock_i) disable iff (srst_i)
    !cfg_readback_o.mask_enable[0] && $changed(filt_lvl[0]));

endmodule : dio_core

// ---- testbench/host_model.sv ----
// Purpose: Host software model that drives the core's register strobes.
// Assumes: Every strobe is a one-cycle pulse that clock_i samples.
// Notes:   Status is sampled in the same cycle as its read strobe.
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic              clock_i,
  // Register strobes and data toward the core
  output logic                   out_wr_o,
  output logic [31:0]            out_data_o,
  output logic                   filt_wr_o,
  output logic [4:0]             filt_data_o,
  output logic                   cfg_wr_o,
  output dio_pkg::irq_cfg_s      cfg_data_o,
  output logic                   stat_rd_o,
  // Status seen by the host
  input  wire logic [31:0]       status_i
);
  import dio_pkg::*;

  // Idle strobes from time zero
  initial
  begin
    out_wr_o    = 1'b0;
    out_data_o  = 32'h0000_0000;
    filt_wr_o   = 1'b0;
    filt_data_o = 5'h00;
    cfg_wr_o    = 1'b0;
    cfg_data_o  = '0;
    stat_rd_o   = 1'b0;
  end

  // Data rides with its strobe for exactly one edge
  task automatic wr_out(input logic [31:0] d);
    @(posedge clock_i);
    out_wr_o   <= 1'b1;
    out_data_o <= d;
    @(posedge clock_i);
    out_wr_o   <= 1'b0;
  endtask : wr_out

  // Software never writes past the top setting
  task automatic wr_filt(input logic [4:0] n);
    if (n > SET_MAX) n = SET_MAX;
    @(posedge clock_i);
    filt_wr_o   <= 1'b1;
    filt_data_o <= n;
    @(posedge clock_i);
    filt_wr_o   <= 1'b0;
  endtask : wr_filt

  task automatic wr_cfg(input irq_cfg_s c);
    @(posedge clock_i);
    cfg_wr_o   <= 1'b1;
    cfg_data_o <= c;
    @(posedge clock_i);
    cfg_wr_o   <= 1'b0;
  endtask : wr_cfg

  // Sampled mid-cycle so the clearing edge cannot race the read
  task automatic rd_stat(output logic [31:0] s);
    @(posedge clock_i);
    stat_rd_o <= 1'b1;
    @(negedge clock_i);
    s = status_i;
    @(posedge clock_i);
    stat_rd_o <= 1'b0;
  endtask : rd_stat
endmodule : host_model

// ---- testbench/test_isolated_dio_filter_irq.sv ----
// Purpose: Self-checking bench for the digital I/O core.
// Assumes: Field pins driven by the bench, strobes by the host model.
// Notes:   Filter runs use small settings to keep the run short.
`timescale 1ns/1ps
module test_isolated_dio_filter_irq;
  import dio_pkg::*;
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic [31:0] field_in_i = 32'h0000_0000;
  logic [31:0] field_out, in_data, out_rb, status, out_data;
  logic [4:0]  filt_set, filt_data;
  logic        irq, out_wr, filt_wr, cfg_wr, stat_rd;
  irq_cfg_s    cfg_rb, cfg_data;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  dio_core i_dio_core (.clock_i(clock_i), .srst_i(srst_i),
    .field_in_i(field_in_i), .field_out_o(field_out),
    .out_wr_i(out_wr), .out_data_i(out_data), .filt_wr_i(filt_wr),
    .filt_data_i(filt_data), .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_data),
    .stat_rd_i(stat_rd), .in_data_o(in_data), .out_readback_o(out_rb),
    .filt_setting_o(filt_set), .cfg_readback_o(cfg_rb),
    .status_o(status), .irq_o(irq));
  host_model i_host_model (.clock_i(clock_i), .out_wr_o(out_wr),
    .out_data_o(out_data), .filt_wr_o(filt_wr), .filt_data_o(filt_data),
    .cfg_wr_o(cfg_wr), .cfg_data_o(cfg_data), .stat_rd_o(stat_rd),
    .status_i(status));

  // 20 MHz clock
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end

  // Expected sticky status for one level step from o to n
  function automatic logic [31:0] exp_stat(input logic [31:0] o, n, m, e);
    return m & ((~e & ~o & n) | (e & o & ~n));
  endfunction : exp_stat

  task automatic check(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask : tick

  task automatic set_field(input logic [31:0] v);
    @(posedge clock_i);
    field_in_i <= v;
  endtask : set_field

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // A hang ends the run; the sequence needs well under 1000 cycles
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [31:0] f, s, m, e;
    void'($urandom(32'hC9F9ABAC));
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    tick(1);
    check(field_out, 32'h0000_0000, "out reset");
    check(status, 32'h0000_0000, "status reset");
    check({27'h0, filt_set}, 32'h0000_0000, "filter reset");
    check(cfg_rb.mask_enable, 32'h0000_0000, "mask reset");
    check(cfg_rb.edge_falling, 32'h0000_0000, "edge reset");
    // Latch writes, readback, and a status read that must not disturb them
    repeat (3)
    begin
      f = $urandom;
      i_host_model.wr_out(f);
      tick(1);
      check(field_out, f, "out drive");
      check(out_rb, f, "out readback");
      i_host_model.rd_stat(s);
      check(field_out, f, "out kept");
    end
    i_host_model.wr_filt(5'h14);
    tick(1);
    check({27'h0, filt_set}, 32'h0000_0014, "filter top");
    i_host_model.wr_filt(5'h00);
    // Bypass: random masks, edges and field steps
    repeat (6)
    begin
      m = $urandom;
      e = $urandom;
      i_host_model.wr_cfg('{mask_enable: m, edge_falling: e});
      tick(1);
      check(cfg_rb.mask_enable, m, "mask readback");
      check(cfg_rb.edge_falling, e, "edge readback");
      f = field_in_i;
      s = $urandom;
      set_field(s);
      tick(8);
      check(in_data, s, "bypass data");
      check(status, exp_stat(f, s, m, e), "edge status");
      check({31'h0, irq}, {31'h0, |exp_stat(f, s, m, e)}, "irq");
      i_host_model.rd_stat(f);
      tick(1);
      check(status, 32'h0000_0000, "status cleared");
      check({31'h0, irq}, 32'h0000_0000, "irq cleared");
    end
    // Corner: every bit enabled on its falling edge only
    m = 32'hFFFF_FFFF;
    i_host_model.wr_cfg('{mask_enable: m, edge_falling: m});
    set_field(m);
    tick(8);
    check(status, 32'h0000_0000, "rise ignored");
    set_field(32'h0000_0000);
    tick(8);
    check(status, m, "fall status");
    check({31'h0, irq}, 32'h0000_0001, "fall irq");
    i_host_model.rd_stat(s);
    check(s, m, "status read");
    // Setting 3: 8 base ticks at 2 per 5 clocks, about 20 clocks
    i_host_model.wr_filt(5'h03);
    i_host_model.wr_cfg('{mask_enable: 32'hFFFF_FFFF, edge_falling: '0});
    f = field_in_i;
    set_field(~f);
    tick(10);
    set_field(f);
    tick(60);
    check(in_data, f, "glitch dropped");
    check(status, 32'h0000_0000, "glitch no irq");
    set_field(~f);
    tick(12);
    check(in_data, f, "not yet stable");
    tick(48);
    check(in_data, ~f, "filtered data");
    check(status, ~f, "filtered edge");
    check({31'h0, irq}, {31'h0, |(~f)}, "filtered irq");
    report_and_stop();
  end
endmodule : test_isolated_dio_filter_irq
